// file: hw/ssa_alloc.sv
// Purpose: Hands device-context slots to block multiplexer channels on begin-I/O.
// Assumes: Requester, completion and configuration logic share clk.
// Notes:   Pool slots are counted, not individually tracked.
`timescale 1ns/1ns
module ssa_alloc
    import ssa_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        byte_chan2_present,
    input  wire logic        cfg_we,
    input  wire logic [5:0]  cfg_index,
    input  wire logic        cfg_valid,
    input  wire logic [2:0]  cfg_chan,
    input  wire logic [3:0]  cfg_base,
    input  wire logic        cfg_span32,
    input  wire logic        cfg_selector,
    output logic             cfg_ack,
    output logic             cfg_err,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic [2:0]  req_chan,
    input  wire logic [7:0]  req_dev,
    output logic             rsp_valid,
    output logic [1:0]       rsp_cc,
    output logic [1:0]       rsp_kind,
    output logic [5:0]       rsp_slot,
    output logic             rsp_selector,
    input  wire logic        done_valid,
    input  wire logic [2:0]  done_chan,
    input  wire logic [7:0]  done_dev,
    output logic [9:0]       pool_free,
    output logic [5:0]       shared_count,
    output logic [5:0]       float_busy
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    ssa_state_t             state_r, state_nxt;
    logic [2:0]             qchan_r, qchan_nxt;
    logic [7:0]             qdev_r, qdev_nxt;
    logic [SSA_SLOTS-1:0]   valid_r, valid_nxt;
    logic [2:0]             chan_r [SSA_SLOTS];
    logic [2:0]             chan_nxt [SSA_SLOTS];
    logic [3:0]             base_r [SSA_SLOTS];
    logic [3:0]             base_nxt [SSA_SLOTS];
    logic [SSA_SLOTS-1:0]   span_r, span_nxt;
    logic [SSA_SLOTS-1:0]   sel_r, sel_nxt;
    logic [5:0]             scnt_r, scnt_nxt;
    logic [9:0]             pused_r, pused_nxt;
    logic [5:0]             fbusy_r, fbusy_nxt;
    logic [7:0]             fdev_r [SSA_NUM_CHAN];
    logic [7:0]             fdev_nxt [SSA_NUM_CHAN];
    logic                   ack_r, ack_nxt;
    logic                   err_r, err_nxt;
    logic                   rv_r, rv_nxt;
    logic [1:0]             cc_r, cc_nxt;
    logic [1:0]             kind_r, kind_nxt;
    logic [5:0]             slot_r, slot_nxt;
    logic                   rsel_r, rsel_nxt;

    // ---------------------------------------------------------------
    // Shared-slot matcher
    // ---------------------------------------------------------------
    ssa_match_if mi ();

    ssa_match u_match (
        .m (mi.matcher)
    );

    // The table is handed to the matcher as stored; queries come from the
    // captured request and from the configuration port.
    always_comb begin
        mi.ent_valid  = valid_r;
        mi.ent_chan   = chan_r;
        mi.ent_base   = base_r;
        mi.ent_span32 = span_r;
        mi.ent_sel    = sel_r;
        mi.q_chan     = qchan_r;
        mi.q_dev      = qdev_r;
        mi.c_chan     = cfg_chan;
        mi.c_skip     = cfg_index;
    end

    // ---------------------------------------------------------------
    // Pool arithmetic
    // ---------------------------------------------------------------
    logic [5:0] shared_limit;
    logic [9:0] pool_size;
    logic [9:0] pool_avail;

    always_comb begin
        shared_limit = byte_chan2_present ? SSA_SHARED_MAX_PAIRED : SSA_SHARED_MAX_ALONE;
        pool_size    = (byte_chan2_present ? SSA_POOL_PAIRED : SSA_POOL_ALONE) -
                       {4'h0, scnt_r};
        // A shrinking pool may already be overdrawn; treat that as empty.
        pool_avail   = (pused_r >= pool_size) ? 10'h000 : (pool_size - pused_r);
    end

    // ---------------------------------------------------------------
    // Configuration checks
    // ---------------------------------------------------------------
    logic       cfg_ok;
    logic [5:0] cfg_newcnt;
    logic [9:0] cfg_newpool;

    always_comb begin
        cfg_newcnt  = scnt_r - {5'h00, valid_r[cfg_index]} + {5'h00, cfg_valid};
        cfg_newpool = (byte_chan2_present ? SSA_POOL_PAIRED : SSA_POOL_ALONE) -
                      {4'h0, cfg_newcnt};
        cfg_ok      = (cfg_index < SSA_SLOTS[5:0]);
        if (cfg_valid) begin
            if (cfg_newcnt > shared_limit) begin
                cfg_ok = 1'b0;
            end
            if ((mi.chan_cnt >= SSA_PER_CHAN_MAX) || (cfg_chan > SSA_LAST_CHAN)) begin
                cfg_ok = 1'b0;
            end
            if (cfg_span32 && cfg_base[0]) begin
                cfg_ok = 1'b0;
            end
            // Taking a slot already bound from the pool would strand a device.
            if (pused_r > cfg_newpool) begin
                cfg_ok = 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------------------
    logic       take_pool;
    logic       rel_pool;
    logic       take_float;
    logic       rel_float;

    always_comb begin
        state_nxt  = state_r;
        qchan_nxt  = qchan_r;
        qdev_nxt   = qdev_r;
        valid_nxt  = valid_r;
        chan_nxt   = chan_r;
        base_nxt   = base_r;
        span_nxt   = span_r;
        sel_nxt    = sel_r;
        scnt_nxt   = scnt_r;
        fbusy_nxt  = fbusy_r;
        fdev_nxt   = fdev_r;
        ack_nxt    = 1'b0;
        err_nxt    = 1'b0;
        rv_nxt     = 1'b0;
        cc_nxt     = cc_r;
        kind_nxt   = kind_r;
        slot_nxt   = slot_r;
        rsel_nxt   = rsel_r;
        take_pool  = 1'b0;
        rel_pool   = 1'b0;
        take_float = 1'b0;
        rel_float  = 1'b0;

        // Configuration write: whole entry replaced, or refused untouched.
        if (cfg_we) begin
            ack_nxt = 1'b1;
            err_nxt = !cfg_ok;
            if (cfg_ok) begin
                valid_nxt[cfg_index] = cfg_valid;
                chan_nxt[cfg_index]  = cfg_chan;
                base_nxt[cfg_index]  = cfg_base;
                span_nxt[cfg_index]  = cfg_span32;
                sel_nxt[cfg_index]   = cfg_selector;
                scnt_nxt             = cfg_newcnt;
            end
        end

        // Completion: floating first, then shared (nothing to do), else pool.
        if (done_valid) begin
            if ((done_chan <= SSA_LAST_CHAN) && fbusy_r[done_chan] &&
                (fdev_r[done_chan] == done_dev)) begin
                rel_float = 1'b1;
                fbusy_nxt[done_chan] = 1'b0;
            end else if (!done_shared(done_chan, done_dev)) begin
                rel_pool = (pused_r != SSA_RST_POOL);
            end
        end

        unique case (state_r)
            SSA_ST_IDLE: begin
                if (req_valid) begin
                    qchan_nxt = req_chan;
                    qdev_nxt  = req_dev;
                    state_nxt = SSA_ST_DECIDE;
                end
            end
            SSA_ST_DECIDE: begin
                rv_nxt    = 1'b1;
                state_nxt = SSA_ST_IDLE;
                cc_nxt    = SSA_CC_STARTED;
                rsel_nxt  = 1'b0;
                slot_nxt  = 6'h00;
                if (qchan_r > SSA_LAST_CHAN) begin
                    cc_nxt   = SSA_CC_NOTOP;
                    kind_nxt = SSA_KIND_NONE;
                end else if (mi.hit) begin
                    kind_nxt = SSA_KIND_SHARED;
                    slot_nxt = mi.hit_idx;
                    rsel_nxt = mi.hit_sel;
                end else if (pool_avail != 10'h000) begin
                    take_pool = 1'b1;
                    kind_nxt  = SSA_KIND_POOL;
                end else if (!fbusy_r[qchan_r]) begin
                    take_float          = 1'b1;
                    fbusy_nxt[qchan_r]  = 1'b1;
                    fdev_nxt[qchan_r]   = qdev_r;
                    kind_nxt            = SSA_KIND_FLOAT;
                    slot_nxt            = {3'h0, qchan_r};
                end else begin
                    cc_nxt   = SSA_CC_BUSY;
                    kind_nxt = SSA_KIND_NONE;
                end
            end
        endcase

        // Take and release in one cycle cancel; a release with nothing bound is ignored.
        pused_nxt = pused_r + {9'h000, take_pool} - {9'h000, rel_pool};
    end

    // True when a completed device sits inside a shared window of its channel.
    function automatic logic done_shared(input logic [2:0] ch, input logic [7:0] dev);
        logic [3:0] up;
        done_shared = 1'b0;
        for (int i = 0; i < SSA_SLOTS; i++) begin
            up = base_r[i] + 4'h1;
            if (valid_r[i] && (chan_r[i] == ch) &&
                ((dev[7:4] == base_r[i]) || (span_r[i] && (dev[7:4] == up)))) begin
                done_shared = 1'b1;
            end
        end
    endfunction : done_shared

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= SSA_ST_IDLE;
            qchan_r <= 3'h0;
            qdev_r  <= 8'h00;
            valid_r <= '0;
            span_r  <= '0;
            sel_r   <= '0;
            scnt_r  <= SSA_RST_CNT;
            pused_r <= SSA_RST_POOL;
            fbusy_r <= 6'h00;
            ack_r   <= 1'b0;
            err_r   <= 1'b0;
            rv_r    <= 1'b0;
            cc_r    <= SSA_CC_STARTED;
            kind_r  <= SSA_KIND_NONE;
            slot_r  <= 6'h00;
            rsel_r  <= 1'b0;
            for (int i = 0; i < SSA_SLOTS; i++) begin
                chan_r[i] <= 3'h0;
                base_r[i] <= 4'h0;
            end
            for (int c = 0; c < SSA_NUM_CHAN; c++) begin
                fdev_r[c] <= 8'h00;
            end
        end else begin
            state_r <= state_nxt;
            qchan_r <= qchan_nxt;
            qdev_r  <= qdev_nxt;
            valid_r <= valid_nxt;
            chan_r  <= chan_nxt;
            base_r  <= base_nxt;
            span_r  <= span_nxt;
            sel_r   <= sel_nxt;
            scnt_r  <= scnt_nxt;
            pused_r <= pused_nxt;
            fbusy_r <= fbusy_nxt;
            fdev_r  <= fdev_nxt;
            ack_r   <= ack_nxt;
            err_r   <= err_nxt;
            rv_r    <= rv_nxt;
            cc_r    <= cc_nxt;
            kind_r  <= kind_nxt;
            slot_r  <= slot_nxt;
            rsel_r  <= rsel_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    // requester reissues later
    // Ready is combinational so a busy answer can be retried next cycle.
    assign req_ready    = (state_r == SSA_ST_IDLE);
    assign cfg_ack      = ack_r;
    assign cfg_err      = err_r;
    assign rsp_valid    = rv_r;
    assign rsp_cc       = cc_r;
    assign rsp_kind     = kind_r;
    assign rsp_slot     = slot_r;
    assign rsp_selector = rsel_r;
    assign shared_count = scnt_r;
    assign float_busy   = fbusy_r;
    assign pool_free    = pool_avail;

endmodule : ssa_alloc

// file: hw/ssa_pkg.sv
// Purpose: Shared constants and types for the device-context slot allocator.
// Assumes: One clock; all inputs come from logic on the same clock.
// Notes:   Counts and limits are sized at the width of what they meet.
package ssa_pkg;

    // ---------------------------------------------------------------
    // Geometry
    // ---------------------------------------------------------------
    localparam int           SSA_NUM_CHAN   = 6;
    localparam int           SSA_CHAN_W     = 3;
    localparam int           SSA_DEV_W      = 8;
    localparam int           SSA_SLOTS      = 40;
    localparam int           SSA_IDX_W      = 6;
    localparam int           SSA_POOL_W     = 10;
    localparam logic [2:0]   SSA_LAST_CHAN  = 3'h5;

    // ---------------------------------------------------------------
    // Limits
    // ---------------------------------------------------------------
    localparam logic [5:0]   SSA_SHARED_MAX_ALONE  = 6'h28;  // 40 slots.
    localparam logic [5:0]   SSA_SHARED_MAX_PAIRED = 6'h20;  // 32 slots.
    localparam logic [5:0]   SSA_PER_CHAN_MAX      = 6'h08;  // Eight per channel.
    localparam logic [9:0]   SSA_POOL_ALONE        = 10'h2E0; // 736 slots.
    localparam logic [9:0]   SSA_POOL_PAIRED       = 10'h1E0; // 480 slots.

    // ---------------------------------------------------------------
    // Answer codes and reset values
    // ---------------------------------------------------------------
    localparam logic [1:0]   SSA_CC_STARTED = 2'h0;
    localparam logic [1:0]   SSA_CC_BUSY    = 2'h2;
    localparam logic [1:0]   SSA_CC_NOTOP   = 2'h3;
    localparam logic [9:0]   SSA_RST_POOL   = 10'h000;
    localparam logic [5:0]   SSA_RST_CNT    = 6'h00;

    typedef enum logic [1:0] {
        SSA_KIND_SHARED = 2'h0,
        SSA_KIND_POOL   = 2'h1,
        SSA_KIND_FLOAT  = 2'h2,
        SSA_KIND_NONE   = 2'h3
    } ssa_kind_t;

    typedef enum logic [1:0] {
        SSA_ST_IDLE   = 2'b01,
        SSA_ST_DECIDE = 2'b10
    } ssa_state_t;

endpackage : ssa_pkg

// file: hw/ssa_match_if.sv
// Purpose: Carries the shared-slot table and lookups between allocator parts.
// Assumes: Table owner drives entries and queries; matcher answers combinationally.
// Notes:   Unpacked arrays keep one entry per index.
`timescale 1ns/1ns
interface ssa_match_if;
    import ssa_pkg::*;
    logic [SSA_SLOTS-1:0]  ent_valid;
    logic [2:0]            ent_chan [SSA_SLOTS];
    logic [3:0]            ent_base [SSA_SLOTS];
    logic [SSA_SLOTS-1:0]  ent_span32;
    logic [SSA_SLOTS-1:0]  ent_sel;
    logic [2:0]            q_chan;
    logic [7:0]            q_dev;
    logic                  hit;
    logic [5:0]            hit_idx;
    logic                  hit_sel;
    logic [2:0]            c_chan;
    logic [5:0]            c_skip;
    logic [5:0]            chan_cnt;

    modport owner (
        output ent_valid, ent_chan, ent_base, ent_span32, ent_sel,
        output q_chan, q_dev, c_chan, c_skip,
        input  hit, hit_idx, hit_sel, chan_cnt
    );
    modport matcher (
        input  ent_valid, ent_chan, ent_base, ent_span32, ent_sel,
        input  q_chan, q_dev, c_chan, c_skip,
        output hit, hit_idx, hit_sel, chan_cnt
    );
endinterface : ssa_match_if

// file: hw/ssa_match.sv
// Purpose: Looks up the shared slot covering a device and counts slots per channel.
// Assumes: Pure combinational; the owner registers what it needs.
// Notes:   Lowest matching index wins if two entries overlap.
`timescale 1ns/1ns
module ssa_match
    import ssa_pkg::*;
(
    ssa_match_if.matcher m
);

    // ---------------------------------------------------------------
    // Address window test
    // ---------------------------------------------------------------
    // A 16-wide slot covers base0..baseF; a 32-wide one also (base+1)0..(base+1)F.
    function automatic logic ssa_in_window(input logic [3:0] base,
                                           input logic       span32,
                                           input logic [7:0] dev);
        logic [3:0] upper;
        upper = base + 4'h1;
        ssa_in_window = (dev[7:4] == base) || (span32 && (dev[7:4] == upper));
    endfunction : ssa_in_window

    logic [SSA_SLOTS-1:0] hitv;
    logic [SSA_SLOTS-1:0] cntv;

    // Per-entry match and per-channel membership.
    genvar gi;
    generate
        for (gi = 0; gi < SSA_SLOTS; gi++) begin : g_ent
            assign hitv[gi] = m.ent_valid[gi] && (m.ent_chan[gi] == m.q_chan) &&
                              ssa_in_window(m.ent_base[gi], m.ent_span32[gi], m.q_dev);
            assign cntv[gi] = m.ent_valid[gi] && (m.ent_chan[gi] == m.c_chan) &&
                              (m.c_skip != 6'(gi));
        end
    endgenerate

    // Priority pick of the lowest hit, and the channel population count.
    always_comb begin
        m.hit      = 1'b0;
        m.hit_idx  = 6'h00;
        m.hit_sel  = 1'b0;
        m.chan_cnt = 6'h00;
        for (int i = SSA_SLOTS - 1; i >= 0; i--) begin
            if (hitv[i]) begin
                m.hit     = 1'b1;
                m.hit_idx = i[5:0];
                m.hit_sel = m.ent_sel[i];
            end
        end
        for (int i = 0; i < SSA_SLOTS; i++) begin
            m.chan_cnt = m.chan_cnt + {5'h00, cntv[i]};
        end
    end

endmodule : ssa_match

// file: verif/ssa_alloc_asserts.sv
// Purpose: Port-level checks of the device-context slot allocator.
// Assumes: One clock, asynchronous active-high reset.
// Notes:   Watches allocator outputs against its inputs.
`timescale 1ns/1ns
module ssa_alloc_asserts
    import ssa_pkg::*;
(
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       byte_chan2_present,
    input wire logic       cfg_we,
    input wire logic       cfg_valid,
    input wire logic [3:0] cfg_base,
    input wire logic       cfg_span32,
    input wire logic       cfg_ack,
    input wire logic       cfg_err,
    input wire logic       req_valid,
    input wire logic       req_ready,
    input wire logic       rsp_valid,
    input wire logic [1:0] rsp_cc,
    input wire logic [1:0] rsp_kind,
    input wire logic       rsp_selector,
    input wire logic       done_valid,
    input wire logic [9:0] pool_free,
    input wire logic [5:0] shared_count,
    input wire logic [5:0] float_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // ------------------------------
    // Request and configuration
    // ------------------------------
    sequence s_taken;
        req_valid && req_ready;
    endsequence
    sequence s_answer;
        !req_ready ##1 rsp_valid;
    endsequence
    a_req_answer: assert property (s_taken |=> s_answer)
        else $error("request not answered in time");
    a_cfg_ack: assert property (cfg_we |=> cfg_ack)
        else $error("write not acknowledged");
    a_odd_base: assert property (cfg_we && cfg_valid && cfg_span32 && cfg_base[0]
        |=> cfg_ack && cfg_err)
        else $error("odd wide base accepted");

    // ------------------------------
    // Counts and slot states
    // ------------------------------
    a_pool_alone: assert property (!byte_chan2_present
        |-> 11'(pool_free) + 11'(shared_count) <= 11'(SSA_POOL_ALONE))
        else $error("pool above alone size");
    a_pool_paired: assert property (byte_chan2_present
        |-> 11'(pool_free) + 11'(shared_count) <= 11'(SSA_POOL_PAIRED))
        else $error("pool above paired size");
    a_shared_cap: assert property (shared_count <= (byte_chan2_present ?
        SSA_SHARED_MAX_PAIRED : SSA_SHARED_MAX_ALONE))
        else $error("shared count above limit");
    a_shared_step: assert property (shared_count != $past(shared_count)
        |-> $past(cfg_we))
        else $error("shared count moved without a write");
    a_float_free: assert property (|($past(float_busy) & ~float_busy)
        |-> $past(done_valid))
        else $error("floating slot freed without completion");
    a_float_mode: assert property (rsp_valid && rsp_kind == SSA_KIND_FLOAT
        |-> rsp_cc == SSA_CC_STARTED && !rsp_selector)
        else $error("floating grant not in multiplexer mode");
    a_busy_none: assert property (rsp_valid && rsp_cc == SSA_CC_BUSY
        |-> rsp_kind == SSA_KIND_NONE)
        else $error("busy answer carries a slot");
endmodule : ssa_alloc_asserts

bind ssa_alloc ssa_alloc_asserts chk_u (.*);

// file: verif/ssa_chan_model.sv
// Purpose: Channel side model that reports completed operations.
// Assumes: Started by the bench with a channel, device and latency.
// Notes:   Idle completion lines toggle so stale values are never trusted.
`timescale 1ns/1ns
module ssa_chan_model
    import ssa_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       go,
    input  wire logic [2:0] go_chan,
    input  wire logic [7:0] go_dev,
    input  wire logic [3:0] go_lat,
    output logic            done_valid,
    output logic [2:0]      done_chan,
    output logic [7:0]      done_dev
);
    logic [3:0] wait_cnt;
    logic [2:0] chan_r;
    logic [7:0] dev_r;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            wait_cnt   <= 4'h0;
            done_valid <= 1'b0;
            done_chan  <= 3'h0;
            done_dev   <= 8'h00;
        end else begin
            done_valid <= 1'b0;
            done_chan  <= ~done_chan;
            done_dev   <= ~done_dev;
            if (go) begin
                wait_cnt <= go_lat;
                chan_r   <= go_chan;
                dev_r    <= go_dev;
            end else if (wait_cnt == 4'h1) begin
                wait_cnt   <= 4'h0;
                done_valid <= 1'b1;
                done_chan  <= chan_r;
                done_dev   <= dev_r;
            end else if (wait_cnt != 4'h0) begin
                wait_cnt <= wait_cnt - 4'h1;
            end
        end
    end
endmodule : ssa_chan_model

// file: verif/ssa_alloc_tb_top.sv
// Purpose: Self-checking bench for the slot allocator.
// Assumes: 250 MHz clock; channel model answers completions.
// Notes:   The pool is drained by real requests.
`timescale 1ns/1ns
module ssa_alloc_tb_top
    import ssa_pkg::*;
;
    logic       clk = 1'b0, reset = 1'b1, byte_chan2_present = 1'b0;
    logic       cfg_we = 1'b0, cfg_valid = 1'b0, cfg_span32 = 1'b0, cfg_selector = 1'b0;
    logic [5:0] cfg_index = 6'h00;
    logic [2:0] cfg_chan = 3'h0, req_chan = 3'h0, fin_chan = 3'h0;
    logic [3:0] cfg_base = 4'h0, fin_lat = 4'h1;
    logic       req_valid = 1'b0, fin_go = 1'b0;
    logic [7:0] req_dev = 8'h00, fin_dev = 8'h00;
    logic       cfg_ack, cfg_err, req_ready, rsp_valid, rsp_selector, done_valid;
    logic [1:0] rsp_cc, rsp_kind;
    logic [5:0] rsp_slot, shared_count, float_busy;
    logic [2:0] done_chan;
    logic [7:0] done_dev;
    logic [9:0] pool_free;
    int         bad_count = 0, tests_run = 0;

    // 4 ns clock.
    always #2 clk = ~clk;

    ssa_alloc dut_u (.clk(clk), .reset(reset), .byte_chan2_present(byte_chan2_present),
        .cfg_we(cfg_we), .cfg_index(cfg_index), .cfg_valid(cfg_valid), .cfg_chan(cfg_chan),
        .cfg_base(cfg_base), .cfg_span32(cfg_span32), .cfg_selector(cfg_selector),
        .cfg_ack(cfg_ack), .cfg_err(cfg_err), .req_valid(req_valid), .req_ready(req_ready),
        .req_chan(req_chan), .req_dev(req_dev), .rsp_valid(rsp_valid), .rsp_cc(rsp_cc),
        .rsp_kind(rsp_kind), .rsp_slot(rsp_slot), .rsp_selector(rsp_selector),
        .done_valid(done_valid), .done_chan(done_chan), .done_dev(done_dev),
        .pool_free(pool_free), .shared_count(shared_count), .float_busy(float_busy));
    ssa_chan_model chan_u (.clk(clk), .reset(reset), .go(fin_go), .go_chan(fin_chan),
        .go_dev(fin_dev), .go_lat(fin_lat), .done_valid(done_valid),
        .done_chan(done_chan), .done_dev(done_dev));

    // ------------------------------
    // Access tasks
    // ------------------------------
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp

    task automatic cfg_wr(input int idx, input logic v, input int ch, input int base,
                          input logic s32, input logic sel, input logic err);
        @(posedge clk);
        cfg_we       <= 1'b1;
        cfg_index    <= 6'(idx);
        cfg_valid    <= v;
        cfg_chan     <= 3'(ch);
        cfg_base     <= 4'(base);
        cfg_span32   <= s32;
        cfg_selector <= sel;
        @(posedge clk);
        cfg_we <= 1'b0;
        #1;
        cmp(cfg_ack, 1'b1, "cfg ack");
        cmp(cfg_err, err, "cfg refusal");
    endtask : cfg_wr

    // Taken next edge; the allocator idles between calls.
    task automatic bio(input logic [2:0] ch, input logic [7:0] dev, input logic [1:0] cc,
                       input logic [1:0] kind, input logic [5:0] slot, input logic sel);
        int n;
        @(posedge clk);
        req_valid <= 1'b1;
        req_chan  <= ch;
        req_dev   <= dev;
        @(posedge clk);
        req_valid <= 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        cmp(rsp_valid, 1'b1, "answer");
        cmp({rsp_cc, rsp_kind}, {cc, kind}, "code and kind");
        cmp({rsp_slot, rsp_selector}, {slot, sel}, "slot and mode");
    endtask : bio

    task automatic fin(input logic [2:0] ch, input logic [7:0] dev, input logic [3:0] lat);
        @(posedge clk);
        fin_go   <= 1'b1;
        fin_chan <= ch;
        fin_dev  <= dev;
        fin_lat  <= lat;
        @(posedge clk);
        fin_go <= 1'b0;
        repeat (int'(lat) + 2) @(posedge clk);
        #1;
    endtask : fin

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict

    // ------------------------------
    // Test sequence
    // ------------------------------
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        cmp(pool_free, SSA_POOL_ALONE, "pool at reset");
        for (int i = 0; i < 40; i++) begin
            cfg_wr(i, 1'b1, i / 8, (i % 8) * 2, 1'b0, 1'(i % 2), 1'b0);
            cmp(pool_free, 16'(int'(SSA_POOL_ALONE) - i - 1), "pool shrink");
        end
        cmp(shared_count, SSA_SHARED_MAX_ALONE, "shared full");
        cfg_wr(39, 1'b1, 0, 12, 1'b0, 1'b0, 1'b1);
        cfg_wr(40, 1'b1, 5, 0, 1'b0, 1'b0, 1'b1);
        cfg_wr(0, 1'b1, 0, 1, 1'b1, 1'b0, 1'b1);
        for (int i = 0; i < 40; i++) begin
            cfg_wr(i, 1'b0, 0, 0, 1'b0, 1'b0, 1'b0);
            cmp(pool_free, 16'(int'(SSA_POOL_ALONE) - 39 + i), "pool grow");
        end
        cfg_wr(0, 1'b1, 0, 2, 1'b1, 1'b0, 1'b0);
        cfg_wr(1, 1'b1, 0, 6, 1'b0, 1'b1, 1'b0);
        bio(3'h0, 8'h3A, SSA_CC_STARTED, SSA_KIND_SHARED, 6'h00, 1'b0);
        bio(3'h0, 8'h20, SSA_CC_STARTED, SSA_KIND_SHARED, 6'h00, 1'b0);
        bio(3'h0, 8'h6F, SSA_CC_STARTED, SSA_KIND_SHARED, 6'h01, 1'b1);
        bio(3'h0, 8'h70, SSA_CC_STARTED, SSA_KIND_POOL, 6'h00, 1'b0);
        cmp(pool_free, 16'(int'(SSA_POOL_ALONE) - 3), "pool after grant");
        for (int c = 1; c < 4; c++) begin
            for (int d = 0; d < 256; d++) begin
                if (pool_free !== 10'h000) begin
                    bio(3'(c), 8'(d), SSA_CC_STARTED, SSA_KIND_POOL, 6'h00, 1'b0);
                end
            end
        end
        cmp(pool_free, 10'h000, "pool drained");
        bio(3'h4, 8'h11, SSA_CC_STARTED, SSA_KIND_FLOAT, 6'h04, 1'b0);
        bio(3'h5, 8'h40, SSA_CC_STARTED, SSA_KIND_FLOAT, 6'h05, 1'b0);
        bio(3'h4, 8'h12, SSA_CC_BUSY, SSA_KIND_NONE, 6'h00, 1'b0);
        cmp(float_busy, 6'h30, "floating held");
        fin(3'h4, 8'h11, 4'h6);
        cmp(float_busy, 6'h20, "floating freed");
        bio(3'h4, 8'h12, SSA_CC_STARTED, SSA_KIND_FLOAT, 6'h04, 1'b0);
        fin(3'h1, 8'h05, 4'h1);
        cmp(pool_free, 10'h001, "pool slot back");
        bio(3'h4, 8'h13, SSA_CC_STARTED, SSA_KIND_POOL, 6'h00, 1'b0);
        bio(3'h6, 8'h01, SSA_CC_NOTOP, SSA_KIND_NONE, 6'h00, 1'b0);
        @(posedge clk);
        reset              <= 1'b1;
        byte_chan2_present <= 1'b1;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        cmp(pool_free, SSA_POOL_PAIRED, "paired pool");
        for (int i = 0; i < 33; i++) begin
            cfg_wr(i, 1'b1, i / 8, (i % 8) * 2, 1'b0, 1'b0, i == 32);
        end
        cmp(shared_count, SSA_SHARED_MAX_PAIRED, "paired shared");
        cmp(pool_free, 16'(int'(SSA_POOL_PAIRED) - 32), "paired shrink");
        give_verdict();
    end

    // Hang guard: the tests need a few thousand cycles.
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        give_verdict();
    end
endmodule : ssa_alloc_tb_top
